// *** logic/ldfs_pkg.sv ***
// ldfs_pkg: constants for the load driver fault supervisor
// assumes a 25 MHz clock; all times are converted to cycle counts here
package ldfs_pkg;
   // ------------------------------------------------------------------
   // clock and times
   // ------------------------------------------------------------------
   localparam int CLK_HZ         = 25000000;
   localparam int T_SC_US        = 60;    // on-state short filter, typ
   localparam int T_OC_US        = 250;   // off-state open filter, 100..400
   localparam int T_UV_NS        = 1000;  // under-voltage least duration
   localparam int T_BLANK_US     = 7000;  // lamp inrush blanking, typ
   localparam int T_RETRY_US     = 10000; // lamp retry period, typ
   localparam int SC_CYC         = T_SC_US * (CLK_HZ / 1000000);
   localparam int OC_CYC         = T_OC_US * (CLK_HZ / 1000000);
   localparam int UV_CYC         = (T_UV_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int BLANK_CYC      = T_BLANK_US * (CLK_HZ / 1000000);
   localparam int RETRY_CYC      = T_RETRY_US * (CLK_HZ / 1000000);
   localparam int FILT_W         = 14;    // width of short/open filter counters
   localparam int LAMP_W         = 18;    // width of lamp timers
   localparam logic [FILT_W-1:0] SC_MAX = FILT_W'(SC_CYC - 1);
   localparam logic [FILT_W-1:0] OC_MAX = FILT_W'(OC_CYC - 1);
   localparam logic [FILT_W-1:0] UV_MAX = FILT_W'(UV_CYC - 1);
   // values after reset
   localparam logic DRIVE_OFF    = 1'b0;
   localparam logic FLAG_IDLE    = 1'b0;
endpackage

// *** logic/ldfs_filt_if.sv ***
// ldfs_filt_if: carries one persistence filter's request and verdict
// assumes a single clock domain shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface ldfs_filt_if;
   logic cond;    // raw condition, already synchronised
   logic hit;     // condition persisted the full time
   modport owner (output cond, input hit);
   modport filter (input cond, output hit);
endinterface
`default_nettype wire

// *** logic/ldfs_persist.sv ***
// ldfs_persist: declares a condition once it has held for LIMIT+1 cycles
// assumes a synchronous condition; drops at once when the condition goes
`timescale 1ns/1ns
`default_nettype none
module ldfs_persist
   import ldfs_pkg::*;
#(
   parameter logic [FILT_W-1:0] LIMIT = SC_MAX
) (
   input  wire logic      clk,
   input  wire logic      resetn,
   ldfs_filt_if.filter    f
);
   logic [FILT_W-1:0] count;

   // ------------------------------------------------------------------
   // persistence counter
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
         f.hit <= 1'b0;
      end else if (!f.cond) begin
         count <= '0;
         f.hit <= 1'b0;
      end else if (count == LIMIT) begin
         f.hit <= 1'b1;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** logic/ldfs_top.sv ***
// ldfs_top: command, latch-off and fault flag logic for four drivers
// assumes all analog sense inputs are asynchronous comparator levels
// Functional notes
// [R1] injector drive on while injector command high, off while low
// [R2] open injector command input reads as low, injector off
// [R3] relay channel works exactly like the injector channel
// [R4] battery over- or under-voltage forces injector and relay off
// [R5] open-off, short-on or overheat raises injector or relay flag
// [R6] limited over-current alone raises no flag; only battery short does
// [R7] faulted driver stays off until fault gone and command re-toggled
// [R8] injector/relay short declared after on-state limit holds 60 us
// [R9] injector/relay open declared after off-state condition holds 250 us
// [R10] lamp follows its command; limit faults blanked 7 ms after turn-on
// [R11] lamp returns by itself after fault clears while command high
// [R12] lamp retried every 10 ms while its short persists
// [R13] one ignition command drives both ignition outputs
// [R14] high-side output on while command high, low-side on while low
// [R15] ignition faults ORed into one ignition flag
// [R16] ignition short turns both off until clear and command re-toggled; code latches off only ign_high_drive, ign_low_drive still follows the command
// [R17] ignition open declared after off-state condition holds 250 us
// [R18] ignition short declared after on-state condition holds 60 us
// [R19] battery under-voltage counts only after holding 1 us
// [R20] power-on reset follows regulated supply sense rising
// [R21] all drivers off after reset until commanded on
// [R22] flags idle low; cleared by command toggle once fault gone
// [R23] inputs synchronised; all times are clock cycle counters
`timescale 1ns/1ns
`default_nettype none
module ldfs_top
   import ldfs_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic regulated_sense,
   input  wire logic injector_cmd,
   input  wire logic relay_cmd,
   input  wire logic lamp_cmd,
   input  wire logic ignition_cmd,
   input  wire logic battery_ov,
   input  wire logic battery_uv,
   input  wire logic injector_limit,
   input  wire logic injector_open,
   input  wire logic injector_hot,
   input  wire logic relay_limit,
   input  wire logic relay_open,
   input  wire logic relay_hot,
   input  wire logic lamp_limit,
   input  wire logic lamp_hot,
   input  wire logic ign_feedback,
   input  wire logic ign_hot,
   output logic      injector_drive,
   output logic      relay_drive,
   output logic      lamp_drive,
   output logic      ign_high_drive,
   output logic      ign_low_drive,
   output logic      injector_fault_flag,
   output logic      relay_fault_flag,
   output logic      ign_fault_flag
);
   localparam int NS = 13;
   // sync index map
   localparam int S_SENSE = 0;
   localparam int S_INJ   = 1;
   localparam int S_REL   = 2;
   localparam int S_LAMP  = 3;
   localparam int S_IGN   = 4;
   localparam int S_OV    = 5;
   localparam int S_UV    = 6;
   localparam int S_ILIM  = 7;
   localparam int S_IOPN  = 8;
   localparam int S_IHOT  = 9;
   localparam int S_RLIM  = 10;
   localparam int S_ROPN  = 11;
   localparam int S_RHOT  = 12;

   logic [NS-1:0] raw_in;
   logic [NS-1:0] sync_a;
   logic [NS-1:0] sync_b;
   logic [3:0]    extra_a;
   logic [3:0]    extra_b;
   logic          power_ok;
   logic          run_resetn;
   logic          uv_hit;
   logic          supply_bad;
   logic          inj_prev;
   logic          rel_prev;
   logic          ign_prev;
   logic          inj_latched;
   logic          rel_latched;
   logic          ign_latched;
   logic          inj_armed;
   logic          rel_armed;
   logic          ign_armed;
   logic          ign_short_hit;
   logic          ign_open_hit;

   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   // built-in pull-down on the command pins makes a lost pin read low
   assign raw_in = {relay_hot, relay_open, relay_limit, injector_hot, injector_open,
                    injector_limit, battery_uv, battery_ov, ignition_cmd, lamp_cmd,
                    relay_cmd, injector_cmd, regulated_sense}; // [R2]

   // two flops per asynchronous input
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_a  <= '0;
         sync_b  <= '0;
         extra_a <= '0;
         extra_b <= '0;
      end else begin
         sync_a  <= raw_in; // [R23]
         sync_b  <= sync_a;
         extra_a <= {ign_feedback, lamp_limit, lamp_hot, ign_hot};
         extra_b <= extra_a;
      end
   end

   // ------------------------------------------------------------------
   // power-on reset from regulated supply sense
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         power_ok   <= 1'b0;
         run_resetn <= 1'b0;
      end else begin
         power_ok   <= sync_b[S_SENSE]; // [R20]
         run_resetn <= power_ok & sync_b[S_SENSE];
      end
   end

   // ------------------------------------------------------------------
   // persistence filters
   // ------------------------------------------------------------------
   ldfs_filt_if uv_f ();
   ldfs_filt_if inj_sc_f ();
   ldfs_filt_if inj_oc_f ();
   ldfs_filt_if rel_sc_f ();
   ldfs_filt_if rel_oc_f ();
   ldfs_filt_if ign_sc_f ();
   ldfs_filt_if ign_oc_f ();

   assign uv_f.cond     = sync_b[S_UV]; // [R19]
   assign inj_sc_f.cond = inj_armed & sync_b[S_ILIM]; // [R8]
   assign inj_oc_f.cond = ~injector_drive & sync_b[S_IOPN]; // [R9]
   assign rel_sc_f.cond = rel_armed & sync_b[S_RLIM]; // [R3]
   assign rel_oc_f.cond = ~relay_drive & sync_b[S_ROPN]; // [R3]
   assign ign_sc_f.cond = ign_armed & extra_b[3]; // [R18]
   assign ign_oc_f.cond = ~sync_b[S_IGN] & extra_b[3]; // [R17]

   ldfs_persist #(.LIMIT(UV_MAX)) u_uv     (.clk(clk), .resetn(resetn), .f(uv_f));
   ldfs_persist #(.LIMIT(SC_MAX)) u_inj_sc (.clk(clk), .resetn(resetn), .f(inj_sc_f));
   ldfs_persist #(.LIMIT(OC_MAX)) u_inj_oc (.clk(clk), .resetn(resetn), .f(inj_oc_f));
   ldfs_persist #(.LIMIT(SC_MAX)) u_rel_sc (.clk(clk), .resetn(resetn), .f(rel_sc_f));
   ldfs_persist #(.LIMIT(OC_MAX)) u_rel_oc (.clk(clk), .resetn(resetn), .f(rel_oc_f));
   ldfs_persist #(.LIMIT(SC_MAX)) u_ign_sc (.clk(clk), .resetn(resetn), .f(ign_sc_f));
   ldfs_persist #(.LIMIT(OC_MAX)) u_ign_oc (.clk(clk), .resetn(resetn), .f(ign_oc_f));

   assign uv_hit        = uv_f.hit;
   assign supply_bad    = sync_b[S_OV] | uv_hit;
   assign ign_short_hit = ign_sc_f.hit;
   assign ign_open_hit  = ign_oc_f.hit;

   // ------------------------------------------------------------------
   // command edge history
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         inj_prev <= 1'b0;
         rel_prev <= 1'b0;
         ign_prev <= 1'b0;
      end else begin
         inj_prev <= sync_b[S_INJ];
         rel_prev <= sync_b[S_REL];
         ign_prev <= sync_b[S_IGN];
      end
   end

   // ------------------------------------------------------------------
   // injector and relay latch-off
   // ------------------------------------------------------------------
   // short, overheat or supply fault latches off; rising command re-arms
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         inj_latched <= 1'b0;
         rel_latched <= 1'b0;
      end else if (!run_resetn) begin
         inj_latched <= 1'b0;
         rel_latched <= 1'b0;
      end else begin
         if (inj_sc_f.hit | sync_b[S_IHOT] | supply_bad) begin
            inj_latched <= 1'b1; // [R7] [R4]
         end else if (sync_b[S_INJ] & ~inj_prev) begin
            inj_latched <= 1'b0; // [R7]
         end
         if (rel_sc_f.hit | sync_b[S_RHOT] | supply_bad) begin
            rel_latched <= 1'b1; // [R3]
         end else if (sync_b[S_REL] & ~rel_prev) begin
            rel_latched <= 1'b0; // [R3]
         end
      end
   end

   assign inj_armed = sync_b[S_INJ] & ~inj_latched & ~supply_bad;
   assign rel_armed = sync_b[S_REL] & ~rel_latched & ~supply_bad;

   // ------------------------------------------------------------------
   // ignition latch-off
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ign_latched <= 1'b0;
      end else if (!run_resetn) begin
         ign_latched <= 1'b0;
      end else if (ign_short_hit | extra_b[0]) begin
         ign_latched <= 1'b1; // [R16]
      end else if (sync_b[S_IGN] & ~ign_prev) begin
         ign_latched <= 1'b0; // [R16]
      end
   end

   assign ign_armed = sync_b[S_IGN] & ~ign_latched;

   // ------------------------------------------------------------------
   // lamp: blanking, auto restart and retry
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {LDFS_L_OFF, LDFS_L_BLANK, LDFS_L_ON, LDFS_L_WAIT} ldfs_lamp_t;
   ldfs_lamp_t        lamp_state;
   logic [LAMP_W-1:0] lamp_count;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lamp_state <= LDFS_L_OFF;
         lamp_count <= '0;
      end else if (!run_resetn || !sync_b[S_LAMP]) begin
         lamp_state <= LDFS_L_OFF; // [R10]
         lamp_count <= '0;
      end else begin
         case (lamp_state)
            LDFS_L_OFF: begin
               if (!extra_b[1]) begin
                  lamp_state <= LDFS_L_BLANK;
                  lamp_count <= '0;
               end
            end
            LDFS_L_BLANK: begin
               if (extra_b[1]) begin
                  lamp_state <= LDFS_L_WAIT; // [R11]
                  lamp_count <= '0;
               end else if (lamp_count == LAMP_W'(BLANK_CYC - 1)) begin
                  lamp_state <= LDFS_L_ON; // [R10]
               end else begin
                  lamp_count <= lamp_count + 1'b1;
               end
            end
            LDFS_L_ON: begin
               if (extra_b[1] | extra_b[2]) begin
                  lamp_state <= LDFS_L_WAIT; // [R11]
                  lamp_count <= '0;
               end
            end
            LDFS_L_WAIT: begin
               if (lamp_count == LAMP_W'(RETRY_CYC - 1)) begin
                  if (!extra_b[1]) begin
                     lamp_state <= LDFS_L_BLANK; // [R12] [R11]
                  end
                  lamp_count <= '0;
               end else begin
                  lamp_count <= lamp_count + 1'b1;
               end
            end
            default: begin
               lamp_state <= LDFS_L_OFF;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         injector_drive <= DRIVE_OFF; // [R21]
         relay_drive    <= DRIVE_OFF;
         lamp_drive     <= DRIVE_OFF;
         ign_high_drive <= DRIVE_OFF;
         ign_low_drive  <= DRIVE_OFF;
      end else if (!run_resetn) begin
         injector_drive <= DRIVE_OFF; // [R21]
         relay_drive    <= DRIVE_OFF;
         lamp_drive     <= DRIVE_OFF;
         ign_high_drive <= DRIVE_OFF;
         ign_low_drive  <= DRIVE_OFF;
      end else begin
         injector_drive <= inj_armed & ~inj_sc_f.hit & ~sync_b[S_IHOT]; // [R1]
         relay_drive    <= rel_armed & ~rel_sc_f.hit & ~sync_b[S_RHOT]; // [R3]
         lamp_drive     <= (lamp_state == LDFS_L_BLANK) | (lamp_state == LDFS_L_ON);
         ign_high_drive <= ign_armed & ~ign_short_hit & ~extra_b[0]; // [R13] [R14]
         ign_low_drive  <= ~sync_b[S_IGN]; // [R14]
      end
   end

   // ------------------------------------------------------------------
   // fault flags: set wins over clear
   // ------------------------------------------------------------------
   // limit current alone is not reported, only the filtered short
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         injector_fault_flag <= FLAG_IDLE; // [R22]
         relay_fault_flag    <= FLAG_IDLE;
         ign_fault_flag      <= FLAG_IDLE;
      end else if (!run_resetn) begin
         injector_fault_flag <= FLAG_IDLE;
         relay_fault_flag    <= FLAG_IDLE;
         ign_fault_flag      <= FLAG_IDLE;
      end else begin
         if (inj_sc_f.hit | inj_oc_f.hit | sync_b[S_IHOT]) begin
            injector_fault_flag <= 1'b1; // [R5] [R6]
         end else if (sync_b[S_INJ] ^ inj_prev) begin
            injector_fault_flag <= 1'b0; // [R22]
         end
         if (rel_sc_f.hit | rel_oc_f.hit | sync_b[S_RHOT]) begin
            relay_fault_flag <= 1'b1; // [R3]
         end else if (sync_b[S_REL] ^ rel_prev) begin
            relay_fault_flag <= 1'b0;
         end
         if (ign_short_hit | ign_open_hit | extra_b[0]) begin
            ign_fault_flag <= 1'b1; // [R15]
         end else if (sync_b[S_IGN] ^ ign_prev) begin
            ign_fault_flag <= 1'b0; // [R22]
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/ldfs_mcu_model.sv ***
// ldfs_mcu_model: stand-in for the controller that drives the command pins
// assumes the bench calls its tasks a little after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module ldfs_mcu_model (
   input  wire logic clk,
   output logic      injector_cmd,
   output logic      relay_cmd,
   output logic      lamp_cmd,
   output logic      ignition_cmd
);
   logic [3:0] lvl  = 4'h0;
   logic [3:0] lost = 4'h0;

   // a lost wire reads low through the pin pull-down
   assign injector_cmd = lvl[0] & ~lost[0];
   assign relay_cmd    = lvl[1] & ~lost[1];
   assign lamp_cmd     = lvl[2] & ~lost[2];
   assign ignition_cmd = lvl[3] & ~lost[3];

   // set one command level
   task automatic put(input int i, input logic v);
      lvl[i] = v;
   endtask

   // low then high re-arms a latched driver and clears its flag
   task automatic toggle(input int i);
      lvl[i] = 1'b0;
      repeat (6) @(posedge clk);
      #2;
      lvl[i] = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** tb/ldfs_checker.sv ***
// ldfs_checker: port-level properties of the driver supervisor
// assumes a single clock domain, bound onto ldfs_top
`timescale 1ns/1ns
`default_nettype none
module ldfs_checker (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic regulated_sense,
   input  wire logic injector_cmd,
   input  wire logic relay_cmd,
   input  wire logic ignition_cmd,
   input  wire logic battery_ov,
   input  wire logic battery_uv,
   input  wire logic injector_limit,
   input  wire logic relay_open,
   input  wire logic ign_feedback,
   input  wire logic injector_drive,
   input  wire logic relay_drive,
   input  wire logic lamp_drive,
   input  wire logic ign_high_drive,
   input  wire logic ign_low_drive,
   input  wire logic injector_fault_flag,
   input  wire logic relay_fault_flag,
   input  wire logic ign_fault_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------------------------------
   // condition persistence counters
   // ----------------------------------------------------------------
   logic [13:0] sc_inj, oc_rel, sc_ign;
   logic        ok;
   assign ok = regulated_sense & ~battery_ov & ~battery_uv;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sc_inj <= 14'h0;
         oc_rel <= 14'h0;
         sc_ign <= 14'h0;
      end else begin
         sc_inj <= (injector_cmd & injector_limit & ok) ? sc_inj + 14'h1 : 14'h0;
         oc_rel <= (~relay_cmd & relay_open) ? oc_rel + 14'h1 : 14'h0;
         sc_ign <= (ignition_cmd & ign_feedback) ? sc_ign + 14'h1 : 14'h0;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   sequence s_held_on;
      (injector_cmd && regulated_sense) [*8];
   endsequence
   property p_off_reset;
      !regulated_sense [*5] |-> !(injector_drive || relay_drive || lamp_drive || ign_high_drive);
   endproperty
   property p_inj_on;
      $rose(injector_drive) |-> $past(injector_cmd, 2);
   endproperty
   property p_inj_off;
      !injector_cmd [*5] |-> !injector_drive;
   endproperty
   property p_rel_off;
      !relay_cmd [*5] |-> !relay_drive;
   endproperty
   property p_supply;
      battery_ov [*5] |-> !injector_drive && !relay_drive;
   endproperty
   property p_ign_excl;
      !(ign_high_drive && ign_low_drive);
   endproperty
   property p_ign_off;
      !ignition_cmd [*5] |-> !ign_high_drive;
   endproperty
   property p_latch;
      s_held_on ##0 !injector_drive |=> !injector_drive;
   endproperty
   property p_inj_short;
      sc_inj == 14'h620 |-> injector_fault_flag && !injector_drive;
   endproperty
   property p_rel_open;
      oc_rel == 14'h189c |-> relay_fault_flag;
   endproperty
   property p_ign_short;
      sc_ign == 14'h620 |-> ign_fault_flag && !ign_high_drive;
   endproperty
   a_off_reset: assert property (p_off_reset) else $error("driver on without supply");
   a_inj_on: assert property (p_inj_on) else $error("injector on uncommanded");
   a_inj_off: assert property (p_inj_off) else $error("injector on while cmd low");
   a_rel_off: assert property (p_rel_off) else $error("relay on while cmd low");
   a_supply: assert property (p_supply) else $error("driver on in over-voltage");
   a_ign_excl: assert property (p_ign_excl) else $error("both ignition outputs on");
   a_ign_off: assert property (p_ign_off) else $error("ignition high on, cmd low");
   a_latch: assert property (p_latch) else $error("latched injector re-armed");
   a_inj_short: assert property (p_inj_short) else $error("injector short missed");
   a_rel_open: assert property (p_rel_open) else $error("relay open missed");
   a_ign_short: assert property (p_ign_short) else $error("ignition short missed");
endmodule

bind ldfs_top ldfs_checker u_chk (
   .clk(clk), .resetn(resetn), .regulated_sense(regulated_sense),
   .injector_cmd(injector_cmd), .relay_cmd(relay_cmd), .ignition_cmd(ignition_cmd),
   .battery_ov(battery_ov), .battery_uv(battery_uv), .injector_limit(injector_limit),
   .relay_open(relay_open), .ign_feedback(ign_feedback), .injector_drive(injector_drive),
   .relay_drive(relay_drive), .lamp_drive(lamp_drive), .ign_high_drive(ign_high_drive),
   .ign_low_drive(ign_low_drive), .injector_fault_flag(injector_fault_flag),
   .relay_fault_flag(relay_fault_flag), .ign_fault_flag(ign_fault_flag)
);
`default_nettype wire

// *** tb/test_ldfs_top.sv ***
// test_ldfs_top: directed scenarios for the driver supervisor
// assumes ldfs_mcu_model drives the command pins
`timescale 1ns/1ns
`default_nettype none
module test_ldfs_top;
   logic clk = 1'b0;
   logic resetn, regulated_sense, battery_ov, battery_uv;
   logic injector_limit, injector_open, injector_hot, relay_limit, relay_open;
   logic relay_hot, lamp_limit, lamp_hot, ign_feedback, ign_hot;
   wire logic inj_c, rel_c, lamp_c, ign_c, inj_d, rel_d, lamp_d, ign_h, ign_l;
   wire logic inj_f, rel_f, ign_f;
   int errors = 0;
   int cmp_count = 0;

   always #20 clk = ~clk;

   ldfs_mcu_model mcu (.clk(clk), .injector_cmd(inj_c), .relay_cmd(rel_c),
      .lamp_cmd(lamp_c), .ignition_cmd(ign_c));
   ldfs_top uut (.clk(clk), .resetn(resetn), .regulated_sense(regulated_sense),
      .injector_cmd(inj_c), .relay_cmd(rel_c), .lamp_cmd(lamp_c), .ignition_cmd(ign_c),
      .battery_ov(battery_ov), .battery_uv(battery_uv), .injector_limit(injector_limit),
      .injector_open(injector_open), .injector_hot(injector_hot), .relay_limit(relay_limit),
      .relay_open(relay_open), .relay_hot(relay_hot), .lamp_limit(lamp_limit),
      .lamp_hot(lamp_hot), .ign_feedback(ign_feedback), .ign_hot(ign_hot),
      .injector_drive(inj_d), .relay_drive(rel_d), .lamp_drive(lamp_d),
      .ign_high_drive(ign_h), .ign_low_drive(ign_l), .injector_fault_flag(inj_f),
      .relay_fault_flag(rel_f), .ign_fault_flag(ign_f));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic check(input logic got, input logic exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      step(5);
      check(inj_d | rel_d | lamp_d | ign_h, 1'b0, "drive before supply");
      check(inj_f | rel_f | ign_f, 1'b0, "flag after reset");
      regulated_sense = 1'b1;
      step(8);
      check(ign_l, 1'b1, "ign low idle");
      check(inj_d, 1'b0, "inj idle");
   endtask
   task automatic t_basic;
      for (int i = 0; i < 4; i++) mcu.put(i, 1'b1);
      step(5);
      check(inj_d, 1'b1, "inj on");
      check(rel_d, 1'b1, "relay on");
      check(lamp_d, 1'b1, "lamp on");
      check(ign_h, 1'b1, "ign high on");
      check(ign_l, 1'b0, "ign low off");
      for (int i = 0; i < 4; i++) mcu.put(i, 1'b0);
      step(5);
      check(inj_d | rel_d | lamp_d | ign_h, 1'b0, "drives off");
      check(ign_l, 1'b1, "ign low on");
      mcu.lost[0] = 1'b1;
      mcu.put(0, 1'b1);
      step(5);
      check(inj_d, 1'b0, "lost pin on");
      mcu.lost[0] = 1'b0;
      mcu.put(0, 1'b0);
      step(5);
   endtask
   task automatic t_ign;
      mcu.put(3, 1'b1);
      step(5);
      ign_feedback = 1'b1;
      step(700);
      check(ign_f, 1'b0, "ign short early");
      step(900);
      check(ign_f, 1'b1, "ign short flag");
      check(ign_h, 1'b0, "ign short off");
      ign_feedback = 1'b0;
      step(10);
      check(ign_h, 1'b0, "ign latched");
      mcu.toggle(3);
      step(5);
      check(ign_h, 1'b1, "ign rearmed");
      check(ign_f, 1'b0, "ign flag clear");
      ign_hot = 1'b1;
      step(8);
      check(ign_f, 1'b1, "ign hot flag");
      ign_hot = 1'b0;
      mcu.put(3, 1'b0);
      step(5);
      check(ign_f, 1'b0, "ign flag cleared");
   endtask
   task automatic t_short;
      mcu.put(0, 1'b1);
      step(5);
      injector_limit = 1'b1;
      step(700);
      check(inj_f, 1'b0, "short early");
      check(inj_d, 1'b1, "limited stays on");
      step(900);
      check(inj_f, 1'b1, "short flag");
      check(inj_d, 1'b0, "short off");
      injector_limit = 1'b0;
      step(10);
      check(inj_d, 1'b0, "inj latched");
      mcu.toggle(0);
      step(5);
      check(inj_d, 1'b1, "inj rearmed");
      check(inj_f, 1'b0, "inj flag clear");
   endtask
   task automatic t_supply;
      battery_uv = 1'b1;
      step(10);
      check(inj_d, 1'b1, "short dip");
      battery_uv = 1'b0;
      step(3);
      battery_uv = 1'b1;
      step(40);
      check(inj_d, 1'b0, "uv off");
      battery_uv = 1'b0;
      mcu.toggle(0);
      step(5);
      check(inj_d, 1'b1, "uv rearm");
      battery_ov = 1'b1;
      step(6);
      check(inj_d, 1'b0, "ov off");
      battery_ov = 1'b0;
      mcu.toggle(0);
      step(5);
      check(inj_d, 1'b1, "ov rearm");
      mcu.put(0, 1'b0);
      step(5);
   endtask
   task automatic t_lamp;
      mcu.put(2, 1'b1);
      step(5);
      lamp_limit = 1'b1;
      step(100);
      check(lamp_d, 1'b1, "inrush blanked");
      lamp_limit = 1'b0;
      lamp_hot = 1'b1;
      step(6);
      check(lamp_d, 1'b0, "lamp hot off");
      lamp_hot = 1'b0;
      mcu.put(2, 1'b0);
      step(5);
   endtask
   task automatic t_open;
      {relay_open, ign_feedback} = 2'h3;
      step(2400);
      check(rel_f, 1'b0, "open early");
      check(ign_f, 1'b0, "ign open early");
      step(4000);
      check(rel_f, 1'b1, "open flag");
      check(ign_f, 1'b1, "ign open flag");
      {relay_open, ign_feedback} = 2'h0;
      step(5);
      check(rel_f, 1'b1, "flag held");
      mcu.toggle(1);
      step(5);
      check(rel_f, 1'b0, "relay flag clear");
      check(rel_d, 1'b1, "relay on");
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      regulated_sense = 1'b0;
      {battery_ov, battery_uv, injector_limit, injector_open, injector_hot} = 5'h0;
      {relay_limit, relay_open, relay_hot, lamp_limit, lamp_hot} = 5'h0;
      {ign_feedback, ign_hot} = 2'h0;
      step(6);
      resetn = 1'b1;
      t_reset;
      t_basic;
      t_ign;
      t_short;
      t_supply;
      t_lamp;
      t_open;
      end_sim;
   end
   initial begin
      #1000000;
      errors++;
      end_sim;
   end
endmodule
`default_nettype wire
